// ---- tof_pkg.sv ----
package tof_pkg;
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 32;
   localparam int GATE_W   = 13;
   localparam int SAMPLE_W = 12;
   localparam int DIFF_W   = 14;
   localparam int WORD_W   = 16;
   localparam int STEP_W   = 6;
   localparam int INT_W    = 16;
   localparam int DIV_W    = 8;
   localparam int CNT_W    = 8;

   localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] REG_DLL    = 8'h04;
   localparam logic [ADDR_W-1:0] REG_INTLEN = 8'h08;
   localparam logic [ADDR_W-1:0] REG_MODDIV = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] REG_CALIB  = 8'h14;

   localparam int CTRL_START   = 0;
   localparam int CTRL_BIN     = 1;
   localparam int CTRL_POL     = 2;
   localparam int CTRL_DLL_EN  = 3;
   localparam int CTRL_EXT_MOD = 6;
   localparam int STAT_BUSY    = 0;
   localparam int STAT_INTEG   = 1;
   localparam int STAT_FRAMES  = 8;

   localparam logic [STEP_W-1:0] DLL_RST    = 6'h00;
   localparam logic [INT_W-1:0]  INTLEN_RST = 16'h0064;
   localparam logic [DIV_W-1:0]  MODDIV_RST = 8'h00;
   localparam int                DLL_STEP_PS = 2000;

   localparam logic [2:0] FULL_LAST_PAIR = 3'h3;
   localparam logic [2:0] BIN_LAST_PAIR  = 3'h1;
   localparam logic [2:0] FULL_LAST_COL  = 3'h7;
   localparam logic [2:0] BIN_LAST_COL   = 3'h3;

   localparam logic signed [DIFF_W-1:0] DIFF_MAX = 14'h07ff;
   localparam logic signed [DIFF_W-1:0] DIFF_MIN = 14'h3800;
   localparam logic [SAMPLE_W-1:0] SAMPLE_MAX = 12'h7ff;
   localparam logic [SAMPLE_W-1:0] SAMPLE_MIN = 12'h800;

   localparam int FULL_SAT = 15;
   localparam int FULL_OVF = 14;
   localparam int FULL_UNF = 13;
   localparam int BIN_SAT  = 12;
   localparam int BIN_OVF  = 14;
   localparam int BIN_UNF  = 13;

   typedef enum logic [2:0] {
      ST_IDLE, ST_INTEG, ST_ADDR, ST_UP, ST_LO
   } seq_state_t;
endpackage : tof_pkg

// ---- conv_if.sv ----
`timescale 1ns/1ns
interface conv_if;
   logic [tof_pkg::GATE_W-1:0]   first_val;
   logic [tof_pkg::GATE_W-1:0]   second_val;
   logic                         sat_in;
   logic [tof_pkg::SAMPLE_W-1:0] sample;
   logic                         sat;
   logic                         ovf;
   logic                         unf;

   modport conv (
      input  first_val, second_val, sat_in,
      output sample, sat, ovf, unf
   );
   modport user (
      output first_val, second_val, sat_in,
      input  sample, sat, ovf, unf
   );
endinterface : conv_if

// ---- pixel_conv.sv ----
`timescale 1ns/1ns
module pixel_conv (
   conv_if.conv c
);
   logic signed [tof_pkg::DIFF_W-1:0] diff;

   always_comb begin
      diff = $signed({1'b0, c.first_val}) - $signed({1'b0, c.second_val});
      c.sat = c.sat_in;
      c.ovf = 1'b0;
      c.unf = 1'b0;
      c.sample = diff[tof_pkg::SAMPLE_W-1:0];
      if (diff >= tof_pkg::DIFF_MAX) begin
         c.sample = tof_pkg::SAMPLE_MAX;
         c.ovf    = 1'b1;
      end else if (diff <= tof_pkg::DIFF_MIN) begin
         c.sample = tof_pkg::SAMPLE_MIN;
         c.unf    = 1'b1;
      end
   end
endmodule : pixel_conv

// ---- mod_gen.sv ----
`timescale 1ns/1ns
module mod_gen #(
   parameter int DIV_W  = tof_pkg::DIV_W,
   parameter int STEP_W = tof_pkg::STEP_W
) (
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   input  wire logic              run_i,
   input  wire logic              ext_sel_i,
   input  wire logic              ext_mod_i,
   input  wire logic              pol_i,
   input  wire logic              dll_en_i,
   input  wire logic [DIV_W-1:0]  div_i,
   input  wire logic [STEP_W-1:0] steps_i,
   output logic                   light_o,
   output logic                   demod_first_o,
   output logic                   demod_second_o,
   output logic [STEP_W-1:0]      tap_o
);
   typedef struct packed {
      logic              sync1;
      logic              sync2;
      logic              phase;
      logic [DIV_W-1:0]  cnt;
      logic              light;
      logic              dm1;
      logic              dm2;
      logic [STEP_W-1:0] tap;
   } mod_state_t;

   mod_state_t s;
   mod_state_t next_s;

   always_comb begin
      logic src;
      src = 1'b0;
      next_s = s;
      next_s.sync1 = ext_mod_i;
      next_s.sync2 = s.sync1;
      if (!run_i) begin
         next_s.cnt   = '0;
         next_s.phase = 1'b0;
      end else if (s.cnt == div_i) begin
         next_s.cnt   = '0;
         next_s.phase = ~s.phase;
      end else begin
         next_s.cnt = s.cnt + 1'b1;
      end
      src = ext_sel_i ? s.sync2 : s.phase;
      next_s.light = (run_i & src) ^ pol_i;
      next_s.dm1 = run_i & src;
      next_s.dm2 = run_i & ~src;
      next_s.tap = dll_en_i ? steps_i : '0;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign light_o        = s.light;
   assign demod_first_o  = s.dm1;
   assign demod_second_o = s.dm2;
   assign tap_o          = s.tap;

   tap_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !dll_en_i |=> tap_o == '0) else $error("tap not zero when disabled");
   tap_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      dll_en_i |=> tap_o == $past(steps_i)) else $error("tap mismatch");
   idle_dark_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !run_i |=> light_o == $past(pol_i)) else $error("light moved idle");
   half_toggle_a: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i)
      run_i && $past(run_i) && s.cnt == div_i |=> s.phase != $past(s.phase))
      else $error("phase did not toggle");
   ext_follow_a: assert property (@(posedge clk_sys_i)
      disable iff (!rst_n_i)
      run_i && ext_sel_i && !pol_i |=> demod_first_o == $past(s.sync2))
      else $error("external modulation not used");
endmodule : mod_gen

// ---- tof_readout.sv ----
`timescale 1ns/1ns
// Overview of operation
// - open-drain light output toggles at modulation rate during integration only
// - push-pull output low whenever open-drain output is off
// - enabled delay line shifts light modulation by programmed steps
// - readable calibration value gives exact delay step time
// - pixels grouped by four and binned by selected mode
// - each measurement is integration then readout with conversion
// - two complementary demodulation drives steer charge during integration
// - first gate minus second gate converts to 12-bit sample and flag
// - converted sample is signed
// - field is 8 by 8, or 4 by 4 when binned
// - binned modes merge each 2x2 group into one pixel
// - rows read in pairs, upper and lower, from centre outward
// - columns read left to right within a row
// - saturation flag travels with its sample, any contributor counts
// - flags embedded in output word, sat bit placement depends on mode, ovf and unf bits fixed
// - converter limit flags raised at top or bottom limit
// - external modulation input used when its select bit is one
// - internal modulation is a 50 percent square wave
// - polarity setting inverts both light outputs together
module tof_readout #(
   parameter logic [31:0] CALIB_VALUE = 32'h0000_0040
) (
   input  wire logic                          clk_sys_i,
   input  wire logic                          rst_n_i,
   input  wire logic [tof_pkg::ADDR_W-1:0]    addr_i,
   input  wire logic [tof_pkg::DATA_W-1:0]    wdata_i,
   input  wire logic                          wr_i,
   input  wire logic                          rd_i,
   output logic [tof_pkg::DATA_W-1:0]         rdata_o,
   input  wire logic                          external_modulation_input_i,
   output logic                               open_drain_light_out_o,
   output logic                               open_drain_light_out_oe_o,
   output logic                               push_pull_light_out_o,
   output logic                               demod_first_o,
   output logic                               demod_second_o,
   output logic [tof_pkg::STEP_W-1:0]         delay_tap_o,
   output logic                               integrating_o,
   output logic                               binned_o,
   output logic [2:0]                         row_upper_o,
   output logic [2:0]                         row_lower_o,
   output logic [2:0]                         col_sel_o,
   input  wire logic [tof_pkg::GATE_W-1:0]    gate_first_upper_i,
   input  wire logic [tof_pkg::GATE_W-1:0]    gate_second_upper_i,
   input  wire logic [tof_pkg::GATE_W-1:0]    gate_first_lower_i,
   input  wire logic [tof_pkg::GATE_W-1:0]    gate_second_lower_i,
   input  wire logic                          sat_upper_i,
   input  wire logic                          sat_lower_i,
   output logic                               sample_valid_o,
   output logic [tof_pkg::WORD_W-1:0]         sample_word_o,
   output logic [2:0]                         sample_row_o,
   output logic [2:0]                         sample_col_o
);
   typedef struct packed {
      tof_pkg::seq_state_t            st;
      logic                           bin;
      logic                           pol;
      logic                           dll_en;
      logic                           ext_sel;
      logic [tof_pkg::STEP_W-1:0]     steps;
      logic [tof_pkg::INT_W-1:0]      int_len;
      logic [tof_pkg::DIV_W-1:0]      mod_div;
      logic [tof_pkg::INT_W-1:0]      cnt;
      logic [2:0]                     pair;
      logic [2:0]                     col;
      logic [2:0]                     row_up;
      logic [2:0]                     row_lo;
      logic [tof_pkg::DATA_W-1:0]     rdata;
      logic [tof_pkg::WORD_W-1:0]     word;
      logic                           valid;
      logic [2:0]                     smp_row;
      logic [2:0]                     smp_col;
      logic [tof_pkg::CNT_W-1:0]      frames;
   } top_state_t;

   top_state_t s;
   top_state_t next_s;
   conv_if     cv ();
   logic       light;
   logic       run;

   // flag placement differs so a binned word keeps its sat bit nearer data
   function automatic logic [tof_pkg::WORD_W-1:0] pack_word(
      input logic                          bin,
      input logic [tof_pkg::SAMPLE_W-1:0]  smp,
      input logic                          sat,
      input logic                          ovf,
      input logic                          unf
   );
      logic [tof_pkg::WORD_W-1:0] w;
      w = '0;
      w[tof_pkg::SAMPLE_W-1:0] = smp;
      if (bin) begin
         w[tof_pkg::BIN_SAT] = sat;
         w[tof_pkg::BIN_OVF] = ovf;
         w[tof_pkg::BIN_UNF] = unf;
      end else begin
         w[tof_pkg::FULL_SAT] = sat;
         w[tof_pkg::FULL_OVF] = ovf;
         w[tof_pkg::FULL_UNF] = unf;
      end
      return w;
   endfunction : pack_word

   function automatic logic [2:0] last_pair(input logic bin);
      return bin ? tof_pkg::BIN_LAST_PAIR : tof_pkg::FULL_LAST_PAIR;
   endfunction : last_pair

   function automatic logic [2:0] last_col(input logic bin);
      return bin ? tof_pkg::BIN_LAST_COL : tof_pkg::FULL_LAST_COL;
   endfunction : last_col

   assign run = (s.st == tof_pkg::ST_INTEG);

   mod_gen #(
      .DIV_W  (tof_pkg::DIV_W),
      .STEP_W (tof_pkg::STEP_W)
   ) u_mod (
      .clk_sys_i      (clk_sys_i),
      .rst_n_i        (rst_n_i),
      .run_i          (run),
      .ext_sel_i      (s.ext_sel),
      .ext_mod_i      (external_modulation_input_i),
      .pol_i          (s.pol),
      .dll_en_i       (s.dll_en),
      .div_i          (s.mod_div),
      .steps_i        (s.steps),
      .light_o        (light),
      .demod_first_o  (demod_first_o),
      .demod_second_o (demod_second_o),
      .tap_o          (delay_tap_o)
   );

   pixel_conv u_conv (
      .c (cv.conv)
   );

   // upper row converts first, lower row shares the same column slot
   always_comb begin
      cv.first_val  = gate_first_upper_i;
      cv.second_val = gate_second_upper_i;
      cv.sat_in     = sat_upper_i;
      if (s.st == tof_pkg::ST_LO) begin
         cv.first_val  = gate_first_lower_i;
         cv.second_val = gate_second_lower_i;
         cv.sat_in     = sat_lower_i;
      end
   end

   always_comb begin
      next_s = s;
      next_s.valid = 1'b0;
      next_s.rdata = '0;

      if (wr_i) begin
         case (addr_i)
            tof_pkg::REG_CTRL: begin
               next_s.bin     = wdata_i[tof_pkg::CTRL_BIN];
               next_s.pol     = wdata_i[tof_pkg::CTRL_POL];
               next_s.dll_en  = wdata_i[tof_pkg::CTRL_DLL_EN];
               next_s.ext_sel = wdata_i[tof_pkg::CTRL_EXT_MOD];
            end
            tof_pkg::REG_DLL:
               next_s.steps = wdata_i[tof_pkg::STEP_W-1:0];
            tof_pkg::REG_INTLEN:
               next_s.int_len = wdata_i[tof_pkg::INT_W-1:0];
            tof_pkg::REG_MODDIV:
               next_s.mod_div = wdata_i[tof_pkg::DIV_W-1:0];
            default: begin
            end
         endcase
      end

      if (rd_i) begin
         case (addr_i)
            tof_pkg::REG_CTRL: begin
               next_s.rdata[tof_pkg::CTRL_BIN]     = s.bin;
               next_s.rdata[tof_pkg::CTRL_POL]     = s.pol;
               next_s.rdata[tof_pkg::CTRL_DLL_EN]  = s.dll_en;
               next_s.rdata[tof_pkg::CTRL_EXT_MOD] = s.ext_sel;
            end
            tof_pkg::REG_DLL:
               next_s.rdata[tof_pkg::STEP_W-1:0] = s.steps;
            tof_pkg::REG_INTLEN:
               next_s.rdata[tof_pkg::INT_W-1:0] = s.int_len;
            tof_pkg::REG_MODDIV:
               next_s.rdata[tof_pkg::DIV_W-1:0] = s.mod_div;
            tof_pkg::REG_STATUS: begin
               next_s.rdata[tof_pkg::STAT_BUSY]  = s.st != tof_pkg::ST_IDLE;
               next_s.rdata[tof_pkg::STAT_INTEG] = run;
               next_s.rdata[tof_pkg::STAT_FRAMES +: tof_pkg::CNT_W] =
                  s.frames;
            end
            tof_pkg::REG_CALIB:
               next_s.rdata = CALIB_VALUE;
            default:
               next_s.rdata = '0;
         endcase
      end

      case (s.st)
         tof_pkg::ST_IDLE: begin
            if (wr_i && addr_i == tof_pkg::REG_CTRL &&
                wdata_i[tof_pkg::CTRL_START]) begin
               next_s.st   = tof_pkg::ST_INTEG;
               next_s.cnt  = s.int_len;
               next_s.pair = '0;
               next_s.col  = '0;
            end
         end
         tof_pkg::ST_INTEG: begin
            if (s.cnt == '0) begin
               next_s.st = tof_pkg::ST_ADDR;
            end else begin
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         tof_pkg::ST_ADDR: begin
            next_s.row_up = last_pair(s.bin) - s.pair;
            next_s.row_lo = last_pair(s.bin) + 3'h1 + s.pair;
            next_s.st     = tof_pkg::ST_UP;
         end
         tof_pkg::ST_UP: begin
            next_s.word    = pack_word(s.bin, cv.sample, cv.sat,
                                       cv.ovf, cv.unf);
            next_s.valid   = 1'b1;
            next_s.smp_row = s.row_up;
            next_s.smp_col = s.col;
            next_s.st      = tof_pkg::ST_LO;
         end
         tof_pkg::ST_LO: begin
            next_s.word    = pack_word(s.bin, cv.sample, cv.sat,
                                       cv.ovf, cv.unf);
            next_s.valid   = 1'b1;
            next_s.smp_row = s.row_lo;
            next_s.smp_col = s.col;
            next_s.st      = tof_pkg::ST_ADDR;
            if (s.col == last_col(s.bin)) begin
               next_s.col = '0;
               if (s.pair == last_pair(s.bin)) begin
                  next_s.pair   = '0;
                  next_s.frames = s.frames + 1'b1;
                  next_s.st     = tof_pkg::ST_IDLE;
               end else begin
                  next_s.pair = s.pair + 3'h1;
               end
            end else begin
               next_s.col = s.col + 3'h1;
            end
         end
         default:
            next_s.st = tof_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s         <= '0;
         s.st      <= tof_pkg::ST_IDLE;
         s.steps   <= tof_pkg::DLL_RST;
         s.int_len <= tof_pkg::INTLEN_RST;
         s.mod_div <= tof_pkg::MODDIV_RST;
      end else begin
         s <= next_s;
      end
   end

   assign rdata_o = s.rdata;
   // open drain pulls when light on
   assign open_drain_light_out_o    = 1'b0;
   assign open_drain_light_out_oe_o = light;
   assign push_pull_light_out_o     = light;
   assign integrating_o  = run;
   assign binned_o       = s.bin;
   assign row_upper_o    = s.row_up;
   assign row_lower_o    = s.row_lo;
   assign col_sel_o      = s.col;
   assign sample_valid_o = s.valid;
   assign sample_word_o  = s.word;
   assign sample_row_o   = s.smp_row;
   assign sample_col_o   = s.smp_col;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence pair_out_s;
      s.st == tof_pkg::ST_ADDR ##1 s.st == tof_pkg::ST_UP
         ##1 sample_valid_o ##1 sample_valid_o;
   endsequence

   pp_follows_od_a: assert property (
      push_pull_light_out_o == open_drain_light_out_oe_o)
      else $error("push-pull differs from open-drain");
   demod_split_a: assert property (
      $past(run) |-> demod_first_o != demod_second_o)
      else $error("demodulation drives not complementary");
   two_samples_a: assert property (
      s.st == tof_pkg::ST_ADDR |-> pair_out_s)
      else $error("row pair did not give two samples");
   centre_pair_a: assert property (
      s.st == tof_pkg::ST_UP |->
         row_upper_o + row_lower_o == 3'(2 * last_pair(s.bin) + 1))
      else $error("row pair not symmetric about centre");
   col_order_a: assert property (
      s.st == tof_pkg::ST_LO && s.col != last_col(s.bin)
         |=> col_sel_o == $past(s.col) + 3'h1)
      else $error("column order broken");
   sat_with_up_a: assert property (
      s.st == tof_pkg::ST_UP && !s.bin
         |=> sample_word_o[tof_pkg::FULL_SAT] == $past(sat_upper_i))
      else $error("saturation flag lost");
   ovf_clamp_a: assert property (
      sample_valid_o && !s.bin && sample_word_o[tof_pkg::FULL_OVF]
         |-> sample_word_o[tof_pkg::SAMPLE_W-1:0] == tof_pkg::SAMPLE_MAX)
      else $error("overflow without top code");
   calib_read_a: assert property (
      rd_i && addr_i == tof_pkg::REG_CALIB |=> rdata_o == CALIB_VALUE)
      else $error("calibration read wrong");
   bin_field_a: assert property (
      s.bin && s.st == tof_pkg::ST_UP |-> row_lower_o <= 3'h3)
      else $error("binned field exceeds four rows");
endmodule : tof_readout

// ---- pix_model.sv ----
`timescale 1ns/1ns
module pix_model (
   input  wire logic [2:0]                 row_upper_i,
   input  wire logic [2:0]                 row_lower_i,
   input  wire logic [2:0]                 col_sel_i,
   output logic [tof_pkg::GATE_W-1:0]      first_upper_o,
   output logic [tof_pkg::GATE_W-1:0]      second_upper_o,
   output logic [tof_pkg::GATE_W-1:0]      first_lower_o,
   output logic [tof_pkg::GATE_W-1:0]      second_lower_o,
   output logic                            sat_upper_o,
   output logic                            sat_lower_o
);
   // charge pattern per pixel reaches both converter limits
   assign first_upper_o  = {row_upper_i, col_sel_i, 7'h00};
   assign first_lower_o  = {row_lower_i, col_sel_i, 7'h00};
   assign second_upper_o = 13'h0bb8;
   assign second_lower_o = 13'h0bb8;
   // over-exposed pixels sit on the diagonal
   assign sat_upper_o = (row_upper_i == col_sel_i);
   assign sat_lower_o = (row_lower_i == col_sel_i);
endmodule : pix_model

// ---- testbench.sv ----
`timescale 1ns/1ns
module testbench;
   // arbitrary calibration code
   localparam logic [31:0] CAL = 32'h0000_0025;
   logic        clk_sys_i = 1'b0;
   logic        rst_n_i   = 1'b0;
   logic [7:0]  addr_i    = 8'h00;
   logic [31:0] wdata_i   = 32'h0;
   logic        wr_i      = 1'b0;
   logic        rd_i      = 1'b0;
   logic        ext_i     = 1'b0;
   logic [31:0] rdata_o;
   logic        od_o, oe_o, pp_o, dm1_o, dm2_o, integ_o, bin_o, val_o;
   logic [5:0]  tap_o;
   logic [2:0]  ru_o, rl_o, col_o, srow_o, scol_o;
   logic [12:0] fu, su, fl, sl;
   logic        satu, satl;
   logic [15:0] word_o;
   int          failures = 0;
   int          n_checks = 0;

   always #50 clk_sys_i = ~clk_sys_i;

   tof_readout #(.CALIB_VALUE(CAL)) u_tof_readout (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .external_modulation_input_i(ext_i),
      .open_drain_light_out_o(od_o), .open_drain_light_out_oe_o(oe_o),
      .push_pull_light_out_o(pp_o), .demod_first_o(dm1_o),
      .demod_second_o(dm2_o), .delay_tap_o(tap_o),
      .integrating_o(integ_o), .binned_o(bin_o), .row_upper_o(ru_o),
      .row_lower_o(rl_o), .col_sel_o(col_o), .gate_first_upper_i(fu),
      .gate_second_upper_i(su), .gate_first_lower_i(fl),
      .gate_second_lower_i(sl), .sat_upper_i(satu), .sat_lower_i(satl),
      .sample_valid_o(val_o), .sample_word_o(word_o),
      .sample_row_o(srow_o), .sample_col_o(scol_o));

   pix_model u_pix_model (
      .row_upper_i(ru_o), .row_lower_i(rl_o), .col_sel_i(col_o),
      .first_upper_o(fu), .second_upper_o(su), .first_lower_o(fl),
      .second_lower_o(sl), .sat_upper_o(satu), .sat_lower_o(satl));

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic end_sim();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      @(negedge clk_sys_i);
      check("rdata", rdata_o, exp);
      @(posedge clk_sys_i);
   endtask : rd

   // one frame; samples checked in stream order, light watched meanwhile
   task automatic frame(input logic bin, input logic ext, input int n);
      int k, i, ic, hi, tg, p, w, row, col, d, half;
      logic [15:0] x;
      logic prev;
      k = 0; ic = 0; hi = 0; tg = 0; prev = oe_o;
      half = bin ? 2 : 4;
      // start strobe inline so the first integration cycle is seen
      addr_i  <= tof_pkg::REG_CTRL;
      wdata_i <= {25'h0, ext, 2'b0, 1'b1, 1'b0, bin, 1'b1};
      wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      // no bus traffic until the frame is over
      for (i = 0; i < 2000 && k < n; i++) begin
         @(negedge clk_sys_i);
         if (integ_o === 1'b1) begin
            ic++;
            hi += int'(oe_o);
            tg += int'(oe_o != prev);
            // drives lag integration by one registered cycle
            if (ic > 1) check("demod", dm1_o ^ dm2_o, 1);
            else check("demod_lag", {dm1_o, dm2_o}, 2'b00);
            check("pp_vs_od", pp_o, oe_o);
            check("binned", bin_o, bin);
         end
         prev = oe_o;
         if (val_o === 1'b1) begin
            p = k / (half * 4);
            w = k % (half * 4);
            col = w / 2;
            row = (w % 2 == 0) ? half - 1 - p : half + p;
            d = row * 1024 + col * 128 - 3000;
            x = {4'h0, d[11:0]};
            if (d >= 2047) x = 16'h47ff;
            if (d <= -2048) x = 16'h2800;
            x[bin ? tof_pkg::BIN_SAT : tof_pkg::FULL_SAT] = (row == col);
            check("word", word_o, x);
            check("row", srow_o, row);
            check("col", scol_o, col);
            k++;
         end
      end
      check("samples", k, n);
      if (k < n) begin
         end_sim();
      end
      check("integ_len", ic, 10);
      if (ext) begin
         check("ext_light", hi >= ic - 3 && tg <= 2, 1);
      end else begin
         check("light_half", hi >= 4 && hi <= 6 && tg > 5, 1);
      end
      repeat (4) @(posedge clk_sys_i);
      $display("test frame bin=%0d ext=%0d done", bin, ext);
   endtask : frame

   initial begin
      logic [7:0]  ra [7];
      logic [31:0] rv [7];
      ra = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
      rv = '{32'h0, 32'h0, 32'h64, 32'h0, 32'h0, CAL, 32'h0};
      repeat (8) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      // reset values, calibration and an unmapped place
      for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
      wr(tof_pkg::REG_CTRL, 32'h4e);
      rd(tof_pkg::REG_CTRL, 32'h4e);
      wr(tof_pkg::REG_MODDIV, 32'h7);
      rd(tof_pkg::REG_MODDIV, 32'h7);
      wr(tof_pkg::REG_MODDIV, 32'h0);
      wr(tof_pkg::REG_DLL, 32'h5);
      wr(tof_pkg::REG_CTRL, 32'h4);
      // outputs settle after the launching edge
      @(negedge clk_sys_i);
      check("tap_off", tap_o, 6'h0);
      check("pol_od", {oe_o, pp_o, od_o}, 3'b110);
      @(posedge clk_sys_i);
      wr(tof_pkg::REG_CTRL, 32'h8);
      @(negedge clk_sys_i);
      check("tap_on", tap_o, 6'h5);
      check("idle_light", {oe_o, pp_o}, 2'b00);
      @(posedge clk_sys_i);
      $display("test registers done");
      wr(tof_pkg::REG_INTLEN, 32'h9);
      frame(1'b0, 1'b0, 64);
      rd(tof_pkg::REG_STATUS, 32'h100);
      frame(1'b1, 1'b0, 16);
      ext_i <= 1'b1;
      frame(1'b0, 1'b1, 64);
      end_sim();
   end
endmodule : testbench
